/* rtl/ppic_ctrl.sv */
// Power-down pin, interrupt, energy detect and reset control with a management slave
`timescale 1ns/1ps
`default_nettype none
`include "ppic_params.svh"

module ppic_ctrl
#(
   parameter int ED_PULSE_PERIOD = 1000,
   parameter int WAKE_CYCLES     = 16
)
(
   input  wire logic       clk,
   input  wire logic       reset_n,
   input  wire logic [4:0] phy_addr_strap,
   input  wire logic       mdc,
   input  wire logic       mdio_in,
   output logic            mdio_out,
   output logic            mdio_oe,
   input  wire logic       powerdown_irq_pin_in,
   output logic            powerdown_irq_pin_out,
   output logic            powerdown_irq_pin_oe,
   input  wire logic [7:0] irq_source,
   input  wire logic       line_energy,
   output logic            power_down,
   output logic            energy_low_power,
   output logic            energy_pulse_tx,
   output logic            power_up_seq,
   output logic            soft_reset_busy
);

   // ==========================================================
   // Registers
   ppic_pkg::ppic_mgmt_state_type   mgmt_state_reg;
   ppic_pkg::ppic_energy_state_type ed_state_reg;
   logic [15:0] basic_control_reg;
   logic [15:0] interrupt_control_reg;
   logic [7:0]  irq_mask_reg;
   logic [7:0]  irq_pending_reg;
   logic [15:0] energy_detect_control_reg;
   logic [4:0]  phy_addr_reg;
   logic        strap_taken_reg;
   logic        mdc_reg;
   logic [15:0] shift_reg;
   logic [5:0]  bit_cnt_reg;
   logic        is_read_reg;
   logic [4:0]  reg_addr_reg;
   logic [7:0]  soft_cnt_reg;
   logic        soft_busy_reg;
   logic [15:0] ed_timer_reg;
   logic [7:0]  wake_cnt_reg;
   logic        power_down_reg;
   logic        pulse_reg;
   logic        mdio_out_reg;
   logic        mdio_oe_reg;
   logic        power_up_reg;

   // ==========================================================
   // Decode
   wire        mdc_rise    = mdc & ~mdc_reg;
   wire        pin_oe_en   = interrupt_control_reg[`PPIC_BIT_PIN_OE];
   wire        irq_enable  = interrupt_control_reg[`PPIC_BIT_IRQ_GLOBAL_ENABLE];
   wire        ed_enable   = energy_detect_control_reg[`PPIC_BIT_ENERGY_ENABLE];
   wire        hit_basic   = reg_addr_reg == `PPIC_OFS_BASIC_CONTROL;
   wire        hit_control = reg_addr_reg == `PPIC_OFS_INTERRUPT_CONTROL;
   wire        hit_status  = reg_addr_reg == `PPIC_OFS_STATUS_MASK;
   wire        hit_energy  = reg_addr_reg == `PPIC_OFS_ENERGY_CONTROL;
   wire        hdr_done    = mgmt_state_reg == ppic_pkg::MGMT_HEADER && mdc_rise
                             && bit_cnt_reg == 6'(`PPIC_HEADER_BITS - 1);
   wire [12:0] hdr_bits    = {shift_reg[11:0], mdio_in};
   // Header is ST low bit, two opcode bits, PHY address, register address
   wire        hdr_ok      = hdr_bits[12] && (hdr_bits[11] ^ hdr_bits[10])
                             && hdr_bits[9:5] == phy_addr_reg;
   wire        turn_end    = mgmt_state_reg == ppic_pkg::MGMT_TURN && mdc_rise
                             && bit_cnt_reg == 6'd1;
   wire        data_end    = mgmt_state_reg == ppic_pkg::MGMT_DATA && mdc_rise
                             && bit_cnt_reg == 6'd15;
   wire        wr_commit   = data_end && !is_read_reg;
   wire [15:0] wr_data     = {shift_reg[14:0], mdio_in};
   // Status is captured as the turnaround ends; that same event clears it
   wire        status_read = turn_end && is_read_reg && hit_status;
   wire        soft_start  = wr_commit && hit_basic
                             && wr_data[`PPIC_BIT_SOFT_RESET] && !soft_busy_reg;
   wire        soft_done   = soft_busy_reg
                             && soft_cnt_reg == 8'(`PPIC_SOFT_RESET_CYCLES - 1);
   wire        ed_lowpower = ed_state_reg == ppic_pkg::ED_LOW;
   wire        ed_change   = ed_enable && (ed_lowpower ? line_energy : !line_energy);
   wire [7:0]  src_now     = irq_source
                             | (8'(ed_change) << `PPIC_SRC_ENERGY);
   wire [7:0]  src_masked  = src_now & irq_mask_reg;
   wire [7:0]  pending_next = (irq_pending_reg & ~{8{status_read}}) | src_masked;
   wire [15:0] read_mux    =
      hit_basic   ? {soft_busy_reg, basic_control_reg[14:0] & 15'h7F80} :
      hit_control ? {14'h0000, interrupt_control_reg[1:0]} :
      hit_status  ? {irq_pending_reg, irq_mask_reg} :
      hit_energy  ? energy_detect_control_reg :
                    16'h0000;
   // Pin-forced power-down only while the pin is an input
   wire        pin_forced  = !pin_oe_en && !powerdown_irq_pin_in;
   wire        pd_next     = basic_control_reg[`PPIC_BIT_POWER_DOWN] | pin_forced;

   // ==========================================================
   // Pin drive
   // Enable is combinational so a fresh source pulls the pin low
   // in the same cycle, not one edge later
   assign powerdown_irq_pin_oe  = pin_oe_en && irq_enable
                                  && (|irq_pending_reg || |src_masked);
   assign powerdown_irq_pin_out = 1'b0;
   assign mdio_out         = mdio_out_reg;
   assign mdio_oe          = mdio_oe_reg;
   assign power_down       = power_down_reg;
   assign energy_low_power = ed_state_reg == ppic_pkg::ED_LOW;
   assign energy_pulse_tx  = pulse_reg;
   assign power_up_seq     = power_up_reg;
   assign soft_reset_busy  = soft_busy_reg;

   // ==========================================================
   // Straps: caught after release of hardware reset, kept through soft reset
   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         strap_taken_reg <= 1'b0;
         phy_addr_reg    <= 5'h00;
      end
      else if (!strap_taken_reg)
      begin
         strap_taken_reg <= 1'b1;
         phy_addr_reg    <= phy_addr_strap;
      end
   end

   // ==========================================================
   // Management frame receiver, runs in power-down too
   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         mgmt_state_reg <= ppic_pkg::MGMT_PREAMBLE;
         mdc_reg        <= 1'b0;
         shift_reg      <= 16'h0000;
         bit_cnt_reg    <= 6'd0;
         is_read_reg    <= 1'b0;
         reg_addr_reg   <= 5'h00;
         mdio_out_reg   <= 1'b0;
         mdio_oe_reg    <= 1'b0;
      end
      else
      begin
         mdc_reg <= mdc;
         if (mdc_rise)
         begin
            unique case (mgmt_state_reg)
               ppic_pkg::MGMT_PREAMBLE:
               begin
                  if (mdio_in)
                     bit_cnt_reg <= (bit_cnt_reg == 6'(`PPIC_PREAMBLE_ONES))
                                    ? bit_cnt_reg : bit_cnt_reg + 6'd1;
                  else if (bit_cnt_reg == 6'(`PPIC_PREAMBLE_ONES))
                  begin
                     mgmt_state_reg <= ppic_pkg::MGMT_HEADER;
                     bit_cnt_reg    <= 6'd0;
                  end
                  else
                     bit_cnt_reg <= 6'd0;
               end
               ppic_pkg::MGMT_HEADER:
               begin
                  shift_reg   <= {shift_reg[14:0], mdio_in};
                  bit_cnt_reg <= bit_cnt_reg + 6'd1;
                  if (hdr_done)
                  begin
                     bit_cnt_reg    <= 6'd0;
                     is_read_reg    <= hdr_bits[11];
                     reg_addr_reg   <= hdr_bits[4:0];
                     mgmt_state_reg <= hdr_ok ? ppic_pkg::MGMT_TURN
                                              : ppic_pkg::MGMT_PREAMBLE;
                  end
               end
               ppic_pkg::MGMT_TURN:
               begin
                  bit_cnt_reg <= bit_cnt_reg + 6'd1;
                  if (is_read_reg && bit_cnt_reg == 6'd0)
                  begin
                     mdio_oe_reg  <= 1'b1;
                     mdio_out_reg <= 1'b0;
                  end
                  if (turn_end)
                  begin
                     bit_cnt_reg    <= 6'd0;
                     mgmt_state_reg <= ppic_pkg::MGMT_DATA;
                     shift_reg      <= {read_mux[14:0], 1'b0};
                     if (is_read_reg)
                        mdio_out_reg <= read_mux[15];
                  end
               end
               ppic_pkg::MGMT_DATA:
               begin
                  bit_cnt_reg <= bit_cnt_reg + 6'd1;
                  if (is_read_reg)
                  begin
                     mdio_out_reg <= shift_reg[15];
                     shift_reg    <= {shift_reg[14:0], 1'b0};
                  end
                  else
                     shift_reg <= wr_data;
                  if (data_end)
                  begin
                     bit_cnt_reg    <= 6'd0;
                     mdio_oe_reg    <= 1'b0;
                     mdio_out_reg   <= 1'b0;
                     mgmt_state_reg <= ppic_pkg::MGMT_PREAMBLE;
                  end
               end
            endcase
         end
      end
   end

   // ==========================================================
   // Software reset sequencer
   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         soft_busy_reg <= 1'b0;
         soft_cnt_reg  <= 8'h00;
      end
      else if (soft_start)
      begin
         soft_busy_reg <= 1'b1;
         soft_cnt_reg  <= 8'h00;
      end
      else if (soft_busy_reg)
      begin
         soft_cnt_reg  <= soft_cnt_reg + 8'h01;
         soft_busy_reg <= !soft_done;
      end
   end

   // ==========================================================
   // Register file; hardware and software reset give the same defaults
   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         basic_control_reg         <= `PPIC_RST_BASIC_CONTROL;
         interrupt_control_reg     <= `PPIC_RST_INTERRUPT_CONTROL;
         irq_mask_reg              <= `PPIC_RST_MASK;
         irq_pending_reg           <= 8'h00;
         energy_detect_control_reg <= `PPIC_RST_ENERGY_CONTROL;
         power_down_reg            <= 1'b0;
      end
      else if (soft_done)
      begin
         basic_control_reg         <= `PPIC_RST_BASIC_CONTROL;
         interrupt_control_reg     <= `PPIC_RST_INTERRUPT_CONTROL;
         irq_mask_reg              <= `PPIC_RST_MASK;
         irq_pending_reg           <= 8'h00;
         energy_detect_control_reg <= `PPIC_RST_ENERGY_CONTROL;
         power_down_reg            <= 1'b0;
      end
      else
      begin
         power_down_reg  <= pd_next;
         irq_pending_reg <= pending_next;
         if (wr_commit && hit_basic)
            basic_control_reg <= wr_data & `PPIC_BASIC_WMASK;
         if (wr_commit && hit_control)
            interrupt_control_reg <= {14'h0000, wr_data[1:0]};
         if (wr_commit && hit_status)
            irq_mask_reg <= wr_data[7:0];
         if (wr_commit && hit_energy)
            energy_detect_control_reg <= wr_data;
      end
   end

   // ==========================================================
   // Energy detect: low power until the line shows energy or detection is disabled
   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         ed_state_reg <= ppic_pkg::ED_ACTIVE;
         ed_timer_reg <= 16'h0000;
         pulse_reg    <= 1'b0;
         wake_cnt_reg <= 8'h00;
         power_up_reg <= 1'b0;
      end
      else
      begin
         pulse_reg <= 1'b0;
         // Mirrors the count after this edge so the output is a flop
         power_up_reg <= wake_cnt_reg > 8'h01;
         if (wake_cnt_reg != 8'h00)
            wake_cnt_reg <= wake_cnt_reg - 8'h01;
         unique case (ed_state_reg)
            ppic_pkg::ED_ACTIVE:
            begin
               ed_timer_reg <= 16'h0000;
               if (ed_enable && !line_energy)
                  ed_state_reg <= ppic_pkg::ED_LOW;
            end
            ppic_pkg::ED_LOW:
            begin
               // Pulses keep the far end aware of us until the line shows energy
               if (ed_timer_reg == 16'(ED_PULSE_PERIOD - 1))
               begin
                  ed_timer_reg <= 16'h0000;
                  pulse_reg    <= 1'b1;
               end
               else
                  ed_timer_reg <= ed_timer_reg + 16'h0001;
               if (!ed_enable || line_energy)
               begin
                  ed_state_reg <= ppic_pkg::ED_ACTIVE;
                  wake_cnt_reg <= 8'(WAKE_CYCLES);
                  power_up_reg <= 1'b1;
               end
            end
         endcase
      end
   end

endmodule

`default_nettype wire

/* rtl/ppic_params.svh */
// Offsets, field positions, reset values and timing counts of the power-down/interrupt/reset block
`ifndef PPIC_PARAMS_SVH
`define PPIC_PARAMS_SVH

// ==========================================================
// Register offsets
`define PPIC_OFS_BASIC_CONTROL      5'h00
`define PPIC_OFS_INTERRUPT_CONTROL  5'h11
`define PPIC_OFS_STATUS_MASK        5'h12
`define PPIC_OFS_ENERGY_CONTROL     5'h1D

// ==========================================================
// Field positions
`define PPIC_BIT_SOFT_RESET         15
`define PPIC_BIT_POWER_DOWN         11
`define PPIC_BIT_PIN_OE             0
`define PPIC_BIT_IRQ_GLOBAL_ENABLE  1
`define PPIC_BIT_ENERGY_ENABLE      15
`define PPIC_SRC_LINK               5
`define PPIC_SRC_ENERGY             6
`define PPIC_BASIC_WMASK            16'h7F80

// ==========================================================
// Reset values
`define PPIC_RST_BASIC_CONTROL      16'h0000
`define PPIC_RST_INTERRUPT_CONTROL  16'h0000
`define PPIC_RST_MASK               8'h00
`define PPIC_RST_ENERGY_CONTROL     16'h0000

// ==========================================================
// Timing
`define PPIC_CLK_MHZ                125
`define PPIC_SOFT_RESET_NS          1000
`define PPIC_SOFT_RESET_CYCLES      ((`PPIC_SOFT_RESET_NS * `PPIC_CLK_MHZ) / 1000)
`define PPIC_PREAMBLE_ONES          32
`define PPIC_HEADER_BITS            13

`endif

/* rtl/ppic_pkg.sv */
// Types shared by the power-down/interrupt/reset block
`default_nettype none

package ppic_pkg;

   // ==========================================================
   // Management frame receiver and energy detect states
   typedef enum logic [3:0]
   {
      MGMT_PREAMBLE = 4'b0001,
      MGMT_HEADER   = 4'b0010,
      MGMT_TURN     = 4'b0100,
      MGMT_DATA     = 4'b1000
   } ppic_mgmt_state_type;

   typedef enum logic [1:0]
   {
      ED_ACTIVE = 2'b01,
      ED_LOW    = 2'b10
   } ppic_energy_state_type;

endpackage

`default_nettype wire

/* test/ppic_ctrl_props.sv */
// Port-level assertions for the power-down/interrupt/reset block
`timescale 1ns/1ps
`default_nettype none
`include "ppic_params.svh"

module ppic_ctrl_props
#(
   parameter int ED_PULSE_PERIOD = 1000,
   parameter int WAKE_CYCLES     = 16
)
(
   input wire logic clk,
   input wire logic reset_n,
   input wire logic mdio_out,
   input wire logic mdio_oe,
   input wire logic powerdown_irq_pin_out,
   input wire logic powerdown_irq_pin_oe,
   input wire logic line_energy,
   input wire logic power_down,
   input wire logic energy_low_power,
   input wire logic energy_pulse_tx,
   input wire logic power_up_seq,
   input wire logic soft_reset_busy
);
   localparam int SOFT_CYCLES = `PPIC_SOFT_RESET_CYCLES;
   int   gap_reg;
   logic seen_reg;
   int   busy_len_reg;
   int   wake_len_reg;

   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         gap_reg      <= 0;
         seen_reg     <= 1'b0;
         busy_len_reg <= 0;
         wake_len_reg <= 0;
      end
      else
      begin
         gap_reg      <= energy_pulse_tx ? 1 : gap_reg + 1;
         seen_reg     <= energy_low_power & (seen_reg | energy_pulse_tx);
         busy_len_reg <= soft_reset_busy ? busy_len_reg + 1 : 0;
         wake_len_reg <= power_up_seq ? wake_len_reg + 1 : 0;
      end
   end

   // ====================================
   // Assertions
   default clocking cb @(posedge clk); endclocking
   default disable iff (!reset_n);

   AST_PIN_LEVEL: assert property (powerdown_irq_pin_oe |-> !powerdown_irq_pin_out)
      else $error("interrupt pin driven high");
   AST_RESET_QUIET: assert property ($rose(reset_n) |-> !powerdown_irq_pin_oe
      && !power_down && !soft_reset_busy && !energy_low_power)
      else $error("outputs active right after reset");
   AST_PULSE_ONE: assert property (energy_pulse_tx |=> !energy_pulse_tx)
      else $error("energy pulse longer than one cycle");
   AST_PULSE_LOW: assert property (energy_pulse_tx |-> energy_low_power || $past(energy_low_power))
      else $error("energy pulse outside low power");
   AST_PULSE_PERIOD: assert property (energy_pulse_tx && seen_reg |-> gap_reg == ED_PULSE_PERIOD)
      else $error("energy pulse spacing wrong");
   AST_SOFT_LEN: assert property ($fell(soft_reset_busy) |-> busy_len_reg == SOFT_CYCLES)
      else $error("software reset length wrong");
   AST_WAKE: assert property ($fell(energy_low_power) && $past(line_energy) |-> ##[0:2] power_up_seq)
      else $error("no power-up sequence on line activity");
   AST_WAKE_LEN: assert property ($fell(power_up_seq) |-> wake_len_reg == WAKE_CYCLES)
      else $error("power-up sequence length wrong");
   AST_TA_ZERO: assert property ($rose(mdio_oe) |-> !mdio_out)
      else $error("turnaround bit not zero");
   AST_OE_HOLD: assert property ($rose(mdio_oe) |-> mdio_oe[*8])
      else $error("read answer dropped early");
endmodule

bind ppic_ctrl ppic_ctrl_props #(.ED_PULSE_PERIOD(ED_PULSE_PERIOD), .WAKE_CYCLES(WAKE_CYCLES))
   u_props (.clk(clk), .reset_n(reset_n), .mdio_out(mdio_out), .mdio_oe(mdio_oe),
   .powerdown_irq_pin_out(powerdown_irq_pin_out), .powerdown_irq_pin_oe(powerdown_irq_pin_oe),
   .line_energy(line_energy), .power_down(power_down), .energy_low_power(energy_low_power),
   .energy_pulse_tx(energy_pulse_tx), .power_up_seq(power_up_seq),
   .soft_reset_busy(soft_reset_busy));
`default_nettype wire

/* test/ppic_mgmt_host.sv */
// Management host model: serial management frames with a pulled-up data line
`timescale 1ns/1ps
`default_nettype none

module ppic_mgmt_host
(
   input  wire logic clk,
   input  wire logic mdio_out,
   input  wire logic mdio_oe,
   output logic      mdc,
   output logic      mdio_in
);
   logic host_oe;
   logic host_bit;

   initial
   begin
      mdc      = 1'b0;
      host_oe  = 1'b0;
      host_bit = 1'b1;
   end

   // Released line floats to the pull-up level
   assign mdio_in = mdio_oe ? mdio_out : (host_oe ? host_bit : 1'b1);

   // ====================================
   // Frame tasks
   task automatic bit_cycle(input logic en, input logic b, output logic s);
      @(posedge clk);
      mdc      <= 1'b0;
      host_oe  <= en;
      host_bit <= b;
      repeat (4) @(posedge clk);
      s = mdio_in;
      mdc <= 1'b1;
      repeat (3) @(posedge clk);
   endtask

   task automatic frame(input logic [4:0] phy, input logic rd, input logic [4:0] ra,
                        input logic [15:0] wd, output logic [15:0] q);
      logic [63:0] v;
      logic        s;
      v = {32'hFFFF_FFFF, 2'b01, rd ? 2'b10 : 2'b01, phy, ra, 2'b10, wd};
      q = 16'h0000;
      for (int i = 0; i < 64; i++)
      begin
         bit_cycle((i < 46) || !rd, v[63-i], s);
         if (i >= 48)
            q[63-i] = s;
      end
      @(posedge clk);
      mdc     <= 1'b0;
      host_oe <= 1'b0;
      repeat (4) @(posedge clk);
   endtask
endmodule
`default_nettype wire

/* test/testbench.sv */
// Self-checking bench for the power-down/interrupt/reset block
`timescale 1ns/1ps
`default_nettype none
`include "ppic_params.svh"

module testbench;
   logic        clk;
   logic        reset_n;
   logic [4:0]  strap;
   logic        mdc;
   logic        mdio_in;
   logic        mdio_out;
   logic        mdio_oe;
   logic        pd_force;
   logic        pin_in;
   logic        pin_out;
   logic        pin_oe;
   logic [7:0]  irq_source;
   logic        line_energy;
   logic        power_down;
   logic        low_power;
   logic        pulse_tx;
   logic        wake;
   logic        busy;
   logic        seen_oe;
   logic [15:0] q;
   int          n_fail;
   int          total_checks;
   int          pulses;

   // Weak pull-up on the shared pin
   assign pin_in = ((pin_oe && !pin_out) || pd_force) ? 1'b0 : 1'b1;

   ppic_ctrl #(.ED_PULSE_PERIOD(20), .WAKE_CYCLES(16)) DUT (.clk(clk), .reset_n(reset_n),
      .phy_addr_strap(strap), .mdc(mdc), .mdio_in(mdio_in), .mdio_out(mdio_out),
      .mdio_oe(mdio_oe), .powerdown_irq_pin_in(pin_in), .powerdown_irq_pin_out(pin_out),
      .powerdown_irq_pin_oe(pin_oe), .irq_source(irq_source), .line_energy(line_energy),
      .power_down(power_down), .energy_low_power(low_power), .energy_pulse_tx(pulse_tx),
      .power_up_seq(wake), .soft_reset_busy(busy));

   ppic_mgmt_host host (.clk(clk), .mdio_out(mdio_out), .mdio_oe(mdio_oe), .mdc(mdc),
      .mdio_in(mdio_in));

   initial
   begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end

   // ====================================
   // Tasks
   task automatic check(input string name, input logic [15:0] exp, input logic [15:0] seen);
      total_checks++;
      if (seen !== exp)
      begin
         n_fail++;
         $display("MISMATCH %s expected %h seen %h", name, exp, seen);
      end
   endtask

   task automatic wr(input logic [4:0] ra, input logic [15:0] d);
      host.frame(strap, 1'b0, ra, d, q);
   endtask

   task automatic rd(input logic [4:0] ra, input logic [15:0] exp, input string name);
      host.frame(strap, 1'b1, ra, 16'h0000, q);
      check(name, exp, q);
   endtask

   // Pin enable is sampled a step after the source's edge, before any clock could latch the source
   task automatic pulse_src(input logic [7:0] s);
      @(posedge clk);
      irq_source <= s;
      #1;
      seen_oe = pin_oe;
      @(posedge clk);
      irq_source <= 8'h00;
   endtask

   task automatic print_verdict;
      if (n_fail == 0 && total_checks > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask

   initial
   begin
      repeat (30000) @(posedge clk);
      n_fail++;
      print_verdict();
   end

   // ====================================
   // Main sequence
   initial
   begin
      reset_n = 1'b0;
      strap = 5'h03;
      pd_force = 1'b0;
      irq_source = 8'h00;
      line_energy = 1'b1;
      n_fail = 0;
      total_checks = 0;
      pulses = 0;
      repeat (10) @(posedge clk);
      reset_n <= 1'b1;
      repeat (2) @(posedge clk);
      check("pin_oe", 16'h0000, 16'(pin_oe));
      rd(`PPIC_OFS_BASIC_CONTROL, 16'h0000, "basic_control");
      rd(`PPIC_OFS_INTERRUPT_CONTROL, 16'h0000, "interrupt_control");
      rd(`PPIC_OFS_STATUS_MASK, 16'h0000, "interrupt_status_mask");
      rd(`PPIC_OFS_ENERGY_CONTROL, 16'h0000, "energy_detect_control");
      rd(5'h05, 16'h0000, "unmapped");
      wr(`PPIC_OFS_BASIC_CONTROL, 16'h0800);
      check("power_down_bit", 16'h0001, 16'(power_down));
      wr(`PPIC_OFS_BASIC_CONTROL, 16'h0000);
      pd_force <= 1'b1;
      repeat (3) @(posedge clk);
      check("power_down_pin", 16'h0001, 16'(power_down));
      rd(`PPIC_OFS_BASIC_CONTROL, 16'h0000, "read_while_down");
      wr(`PPIC_OFS_INTERRUPT_CONTROL, 16'h0001);
      repeat (3) @(posedge clk);
      check("power_down_left", 16'h0000, 16'(power_down));
      pd_force <= 1'b0;
      wr(`PPIC_OFS_INTERRUPT_CONTROL, 16'h0003);
      rd(`PPIC_OFS_INTERRUPT_CONTROL, 16'h0003, "interrupt_control");
      wr(`PPIC_OFS_STATUS_MASK, 16'h0060);
      rd(`PPIC_OFS_STATUS_MASK, 16'h0060, "interrupt_status_mask");
      pulse_src(8'h08);
      check("masked_source", 16'h0000, 16'(seen_oe));
      pulse_src(8'h20);
      check("async_assert", 16'h0001, 16'(seen_oe));
      rd(`PPIC_OFS_STATUS_MASK, 16'h2060, "pending_link");
      check("pin_released", 16'h0000, 16'(pin_oe));
      rd(`PPIC_OFS_STATUS_MASK, 16'h0060, "pending_cleared");
      wr(`PPIC_OFS_INTERRUPT_CONTROL, 16'h0001);
      pulse_src(8'h20);
      check("global_disable", 16'h0000, 16'(seen_oe));
      host.frame(strap, 1'b1, `PPIC_OFS_STATUS_MASK, 16'h0000, q);
      wr(`PPIC_OFS_INTERRUPT_CONTROL, 16'h0003);
      line_energy <= 1'b0;
      wr(`PPIC_OFS_ENERGY_CONTROL, 16'h8000);
      repeat (200)
      begin
         @(posedge clk);
         pulses += pulse_tx;
      end
      check("low_power", 16'h0001, 16'(low_power));
      check("ed_pulses", 16'h0001, 16'(pulses >= 8));
      check("energy_irq", 16'h0001, 16'(pin_oe));
      rd(`PPIC_OFS_STATUS_MASK, 16'h4060, "pending_energy");
      line_energy <= 1'b1;
      repeat (3) @(posedge clk);
      check("woken", 16'h0000, 16'(low_power));
      check("power_up_seq", 16'h0001, 16'(wake));
      wr(`PPIC_OFS_BASIC_CONTROL, 16'h8000);
      check("soft_busy", 16'h0001, 16'(busy));
      repeat (375) @(posedge clk);
      rd(`PPIC_OFS_BASIC_CONTROL, 16'h0000, "reset_bit_clear");
      rd(`PPIC_OFS_INTERRUPT_CONTROL, 16'h0000, "soft_default");
      rd(`PPIC_OFS_ENERGY_CONTROL, 16'h0000, "soft_default_ed");
      wr(`PPIC_OFS_STATUS_MASK, 16'h00FF);
      rd(`PPIC_OFS_STATUS_MASK, 16'h00FF, "mask_before_reset");
      reset_n <= 1'b0;
      strap <= 5'h1A;
      repeat (125) @(posedge clk);
      reset_n <= 1'b1;
      repeat (2) @(posedge clk);
      rd(`PPIC_OFS_STATUS_MASK, 16'h0000, "hw_default");
      host.frame(5'h03, 1'b1, `PPIC_OFS_STATUS_MASK, 16'h0000, q);
      check("old_address", 16'hFFFF, q);
      print_verdict();
   end
endmodule
`default_nettype wire
